// ### inc/lpma_pkg.sv
package lpma_pkg;

   // Power modes, ordered from shallowest to deepest.
   typedef enum logic [2:0] {
      LPMA_ACTIVE    = 3'h0,
      LPMA_CPU_OFF0  = 3'h1,
      LPMA_CPU_OFF1  = 3'h2,
      LPMA_STANDBY2  = 3'h3,
      LPMA_LF_STBY   = 3'h4,
      LPMA_ALL_OFF   = 3'h5
   } lpma_mode_t;

   // Peripheral clock states.
   typedef enum logic [1:0] {
      LPMA_ST_NONE   = 2'h0,
      LPMA_ST_UNCLK  = 2'h1,
      LPMA_ST_LF     = 2'h2,
      LPMA_ST_HF     = 2'h3
   } lpma_state_t;

   // Clock source selection per clocked peripheral.
   localparam logic [2:0] LPMA_SRC_OFF    = 3'h0;
   localparam logic [2:0] LPMA_SRC_SUBSYS = 3'h1;
   localparam logic [2:0] LPMA_SRC_AUX    = 3'h2;
   localparam logic [2:0] LPMA_SRC_VLO    = 3'h3;
   localparam logic [2:0] LPMA_SRC_MODULE_OSCILLATOR_CLOCK = 3'h4;
   localparam logic [2:0] LPMA_SRC_EXT    = 3'h5;
   localparam logic [2:0] LPMA_SRC_WAIT   = 3'h6;

   // Boundary between low and high frequency, in Hz.
   localparam int unsigned LPMA_LF_LIMIT_HZ = 50000;
   localparam logic [31:0] LPMA_LF_LIMIT    = 32'(LPMA_LF_LIMIT_HZ);

   localparam lpma_mode_t LPMA_MODE_RST = LPMA_ACTIVE;

endpackage

// ### verilog/lpma_classify.sv
`timescale 1ns/1ps
// Classifies one peripheral from its enable, clock source and external rate.
module lpma_classify
   import lpma_pkg::*;
(
   // Peripheral setup
   input  wire logic        en_i,
   input  wire logic [2:0]  src_i,
   input  wire logic [31:0] ext_hz_i,
   input  wire logic        lf_ext_unclk_i,
   // Result
   output lpma_state_t      state_o
);
   always_comb begin
      state_o = LPMA_ST_NONE;
      if (en_i) begin
         unique case (src_i)
            LPMA_SRC_SUBSYS,
            LPMA_SRC_MODULE_OSCILLATOR_CLOCK: state_o = LPMA_ST_HF;
            LPMA_SRC_AUX,
            LPMA_SRC_VLO:    state_o = LPMA_ST_LF;
            LPMA_SRC_EXT: begin
               if (ext_hz_i > LPMA_LF_LIMIT) begin
                  state_o = LPMA_ST_HF;
               end else if (lf_ext_unclk_i) begin
                  state_o = LPMA_ST_UNCLK;
               end else begin
                  state_o = LPMA_ST_LF;
               end
            end
            LPMA_SRC_WAIT:   state_o = LPMA_ST_UNCLK;
            default:         state_o = LPMA_ST_NONE;
         endcase
      end
   end
endmodule

// ### verilog/lpma_arbiter.sv
`timescale 1ns/1ps
// Summary of operation
// - Above 50 kHz clock means high-frequency
// - At or below 50 kHz means low-frequency
// - No internal clock means unclocked
// - Unsupported request falls back to supported mode
// - DMA transfers only in active mode; active is held only for a trigger that arrives outside active mode
// - DMA trigger wakes to active temporarily
// - Accelerators busy hold off low power
// - Async receive waiting for start: unclocked
// - I2C target idle or slow: unclocked
// - Timers, I2C controller on subsystem: high
// - Timers, I2C controller on auxiliary: low
// - SPI target above 50 kHz: high
// - Segment display driver is low-frequency
// - Converter: subsystem high, auxiliary low, trigger-wait unclocked
// - Auxiliary-clocked peripherals run in low standby
// - Unclocked modules run with all clocks off
module lpma_arbiter
   import lpma_pkg::*;
#(
   parameter int NPER = 8
)
(
   // Clock and reset
   input  wire logic                  mclk_i,
   input  wire logic                  rst_b_i,
   // CPU request
   input  wire logic [2:0]            cpu_mode_req_i,
   // Generic peripherals: enable, source, external rate, slow-external-unclocked
   input  wire logic [NPER-1:0]       per_en_i,
   input  wire logic [NPER-1:0][2:0]  per_src_i,
   input  wire logic [NPER-1:0][31:0] per_ext_hz_i,
   input  wire logic [NPER-1:0]       per_ext_unclk_i,
   // Serial port in asynchronous receive mode
   input  wire logic                  uart_en_i,
   input  wire logic [2:0]            uart_src_i,
   input  wire logic                  uart_wait_start_i,
   // Serial port in I2C target mode
   input  wire logic                  i2ct_en_i,
   input  wire logic                  i2ct_wait_start_i,
   input  wire logic [31:0]           i2ct_ext_hz_i,
   // Serial port in SPI target mode
   input  wire logic                  spit_en_i,
   input  wire logic [31:0]           spit_ext_hz_i,
   input  wire logic                  spit_slow_unclk_i,
   // Segment display driver
   input  wire logic                  seg_en_i,
   // SAR converter
   input  wire logic                  adc_en_i,
   input  wire logic [2:0]            adc_src_i,
   input  wire logic                  adc_wait_trig_i,
   // Always-unclocked analog modules
   input  wire logic                  analog_en_i,
   // DMA
   input  wire logic                  dma_trig_i,
   input  wire logic                  dma_busy_i,
   // Active-only accelerators
   input  wire logic                  crc_busy_i,
   input  wire logic                  mpy_busy_i,
   input  wire logic                  aes_busy_i,
   // Mode outputs to the clock system
   output lpma_mode_t                 mode_o,
   output logic                       subsys_clk_en_o,
   output logic                       aux_clk_en_o,
   output logic                       cpu_clk_en_o,
   output logic                       dma_active_o,
   output logic                       fallback_o
);
   import lpma_pkg::*;

   localparam int NALL = NPER + 5;

   lpma_state_t st [NALL];
   lpma_mode_t  mode_ff;
   lpma_mode_t  nxt_mode;
   lpma_mode_t  req_mode;
   lpma_mode_t  limit_mode;
   lpma_mode_t  granted;
   logic        any_hf;
   logic        any_lf;
   logic        dma_wake_ff;
   logic        fallback_ff;
   logic        accel_busy;
   logic [2:0]  uart_src_eff;
   logic [2:0]  adc_src_eff;
   logic [2:0]  seg_src;

   // classify each timer, controller or watchdog.
   // sources decide high or low frequency.
   genvar g;
   generate
      for (g = 0; g < NPER; g++) begin : g_per
         lpma_classify u_cls (
            .en_i           (per_en_i[g]),
            .src_i          (per_src_i[g]),
            .ext_hz_i       (per_ext_hz_i[g]),
            .lf_ext_unclk_i (per_ext_unclk_i[g]),
            .state_o        (st[g])
         );
      end
   endgenerate

   assign uart_src_eff = uart_wait_start_i ? LPMA_SRC_WAIT : uart_src_i;
   lpma_classify u_uart (
      .en_i           (uart_en_i),
      .src_i          (uart_src_eff),
      .ext_hz_i       (32'h0),
      .lf_ext_unclk_i (1'b0),
      .state_o        (st[NPER])
   );

   lpma_classify u_i2ct (
      .en_i           (i2ct_en_i),
      .src_i          (i2ct_wait_start_i ? LPMA_SRC_WAIT : LPMA_SRC_EXT),
      .ext_hz_i       (i2ct_ext_hz_i),
      .lf_ext_unclk_i (1'b1),
      .state_o        (st[NPER+1])
   );

   lpma_classify u_spit (
      .en_i           (spit_en_i),
      .src_i          (LPMA_SRC_EXT),
      .ext_hz_i       (spit_ext_hz_i),
      .lf_ext_unclk_i (spit_slow_unclk_i),
      .state_o        (st[NPER+2])
   );

   assign seg_src = LPMA_SRC_AUX;
   lpma_classify u_seg (
      .en_i           (seg_en_i),
      .src_i          (seg_src),
      .ext_hz_i       (32'h0),
      .lf_ext_unclk_i (1'b0),
      .state_o        (st[NPER+3])
   );

   assign adc_src_eff = adc_wait_trig_i ? LPMA_SRC_WAIT : adc_src_i;
   lpma_classify u_adc (
      .en_i           (adc_en_i),
      .src_i          (adc_src_eff),
      .ext_hz_i       (32'h0),
      .lf_ext_unclk_i (1'b0),
      .state_o        (st[NPER+4])
   );

   always_comb begin
      any_hf = 1'b0;
      any_lf = 1'b0;
      for (int i = 0; i < NALL; i++) begin
         if (st[i] == LPMA_ST_HF) begin
            any_hf = 1'b1;
         end
         if (st[i] == LPMA_ST_LF) begin
            any_lf = 1'b1;
         end
      end
   end

   // low keeps auxiliary, unclocked allows all-off.
   // The analog modules and a waiting DMA are unclocked, so they never limit.
   always_comb begin
      if (any_hf) begin
         limit_mode = LPMA_CPU_OFF1;
      end else if (any_lf) begin
         limit_mode = LPMA_LF_STBY;
      end else begin
         limit_mode = LPMA_ALL_OFF;
      end
   end

   always_comb begin
      if (cpu_mode_req_i > 3'(LPMA_ALL_OFF)) begin
         req_mode = LPMA_ALL_OFF;
      end else begin
         req_mode = lpma_mode_t'(cpu_mode_req_i);
      end
   end

   // external rates are trusted as given.
   assign granted = (req_mode > limit_mode) ? limit_mode : req_mode;

   assign accel_busy = crc_busy_i | mpy_busy_i | aes_busy_i;

   always_comb begin
      nxt_mode = granted;
      if (accel_busy && granted > mode_ff) begin
         nxt_mode = mode_ff;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
         mode_ff <= LPMA_MODE_RST;
      end else begin
         mode_ff <= nxt_mode;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
         fallback_ff <= 1'b0;
      end else begin
         fallback_ff <= (req_mode > limit_mode);
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
         dma_wake_ff <= 1'b0;
      end else if (dma_trig_i && mode_ff != LPMA_ACTIVE) begin
         dma_wake_ff <= 1'b1;
      end else if (!dma_busy_i && !dma_trig_i) begin
         dma_wake_ff <= 1'b0;
      end
   end

   assign mode_o          = dma_wake_ff ? LPMA_ACTIVE : mode_ff;
   assign dma_active_o    = dma_wake_ff;
   assign cpu_clk_en_o    = (mode_o == LPMA_ACTIVE) & ~dma_wake_ff;
   assign subsys_clk_en_o = (mode_o <= LPMA_CPU_OFF1);
   assign aux_clk_en_o    = (mode_o <= LPMA_LF_STBY);
   assign fallback_o      = fallback_ff;

endmodule

// ### sim/lpma_arbiter_properties.sv
`timescale 1ns/1ps
module lpma_arbiter_chk
   import lpma_pkg::*;
(
   // Clock and reset
   input  wire logic       mclk_i,
   input  wire logic       rst_b_i,
   // Requests
   input  wire logic [2:0] cpu_mode_req_i,
   input  wire logic       dma_trig_i,
   input  wire logic       dma_busy_i,
   input  wire logic       crc_busy_i,
   input  wire logic       mpy_busy_i,
   input  wire logic       aes_busy_i,
   // Outputs
   input  wire lpma_mode_t mode_o,
   input  wire logic       subsys_clk_en_o,
   input  wire logic       aux_clk_en_o,
   input  wire logic       cpu_clk_en_o,
   input  wire logic       dma_active_o,
   input  wire logic       fallback_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!rst_b_i);
   wire logic acc = crc_busy_i | mpy_busy_i | aes_busy_i;
   a_subsys_map: assert property (subsys_clk_en_o == (mode_o <= LPMA_CPU_OFF1))
      else $error("subsystem clock enable wrong");
   a_aux_map: assert property (aux_clk_en_o == (mode_o <= LPMA_LF_STBY))
      else $error("auxiliary clock enable wrong");
   a_cpu_map: assert property (cpu_clk_en_o == (mode_o == LPMA_ACTIVE && !dma_active_o))
      else $error("cpu clock enable wrong");
   a_dma_wake: assert property (dma_trig_i && mode_o != LPMA_ACTIVE |=> dma_active_o)
      else $error("trigger did not wake");
   a_dma_stays: assert property (dma_active_o && (dma_trig_i || dma_busy_i) |=>
      dma_active_o && mode_o == LPMA_ACTIVE) else $error("transfer left active mode");
   a_dma_ends: assert property (dma_active_o && !dma_trig_i && !dma_busy_i |=>
      !dma_active_o) else $error("wake did not end");
   a_fallback_shallower: assert property (fallback_o |->
      dma_active_o || mode_o < $past(cpu_mode_req_i)) else $error("fallback not shallower");
   a_accel_hold: assert property (acc && !dma_active_o |=>
      dma_active_o || mode_o <= $past(mode_o)) else $error("went deeper while busy");
   c_fallback: cover property (fallback_o);
   c_all_off: cover property (mode_o == LPMA_ALL_OFF);
   c_wake: cover property (dma_active_o ##1 !dma_active_o);
endmodule
bind lpma_arbiter lpma_arbiter_chk i_chk (.mclk_i, .rst_b_i, .cpu_mode_req_i, .dma_trig_i,
   .dma_busy_i, .crc_busy_i, .mpy_busy_i, .aes_busy_i, .mode_o, .subsys_clk_en_o,
   .aux_clk_en_o, .cpu_clk_en_o, .dma_active_o, .fallback_o);

// ### sim/lpma_dma_model.sv
`timescale 1ns/1ps
module lpma_dma_model (
   // Clock and reset
   input  wire logic       mclk_i,
   input  wire logic       rst_b_i,
   // Bench command
   input  wire logic       go_i,
   input  wire logic [7:0] len_i,
   // Towards the arbiter
   output logic            dma_trig_o,
   output logic            dma_busy_o
);
   logic [7:0] left_ff;
   always_ff @(posedge mclk_i) begin
      dma_trig_o <= rst_b_i & go_i;
      if (!rst_b_i) begin
         left_ff <= 8'h0;
      end else if (go_i) begin
         left_ff <= len_i;
      end else if (left_ff != 8'h0) begin
         left_ff <= left_ff - 8'h1;
      end
   end
   assign dma_busy_o = (left_ff != 8'h0);
endmodule

// ### sim/testbench.sv
`timescale 1ns/1ps
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin err_count++; $display("wrong value %s expected %0h seen %0h", n, e, s); end end
module testbench;
   import lpma_pkg::*;
   localparam logic [31:0] LIM = 32'h0000C350;
   logic             mclk_i = 1'b0, rst_b_i = 1'b0, dma_go = 1'b0;
   logic [7:0]       dma_len = 8'h0;
   logic [2:0]       cpu_mode_req_i = 3'h0, uart_src_i = 3'h1, adc_src_i = 3'h1;
   logic [1:0]       per_en_i = 2'h0, per_ext_unclk_i = 2'h0;
   logic [1:0][2:0]  per_src_i = '0;
   logic [1:0][31:0] per_ext_hz_i = '0;
   logic [31:0]      i2ct_ext_hz_i = '0, spit_ext_hz_i = '0;
   logic             uart_en_i = 1'b0, uart_wait_start_i = 1'b0, i2ct_en_i = 1'b0;
   logic             i2ct_wait_start_i = 1'b0, spit_en_i = 1'b0, spit_slow_unclk_i = 1'b0;
   logic             seg_en_i = 1'b0, adc_en_i = 1'b0, adc_wait_trig_i = 1'b0;
   logic             analog_en_i = 1'b0, crc_busy_i = 1'b0, mpy_busy_i = 1'b0;
   logic             aes_busy_i = 1'b0, dma_trig_i, dma_busy_i;
   lpma_mode_t       mode_o;
   logic             subsys_clk_en_o, aux_clk_en_o, cpu_clk_en_o, dma_active_o, fallback_o;
   int               err_count = 0, n_compared = 0;
   always #4 mclk_i = ~mclk_i;
   lpma_arbiter #(.NPER(2)) i_dut (.mclk_i, .rst_b_i, .cpu_mode_req_i, .per_en_i, .per_src_i,
      .per_ext_hz_i, .per_ext_unclk_i, .uart_en_i, .uart_src_i, .uart_wait_start_i, .i2ct_en_i,
      .i2ct_wait_start_i, .i2ct_ext_hz_i, .spit_en_i, .spit_ext_hz_i, .spit_slow_unclk_i,
      .seg_en_i, .adc_en_i, .adc_src_i, .adc_wait_trig_i, .analog_en_i, .dma_trig_i,
      .dma_busy_i, .crc_busy_i, .mpy_busy_i, .aes_busy_i, .mode_o, .subsys_clk_en_o,
      .aux_clk_en_o, .cpu_clk_en_o, .dma_active_o, .fallback_o);
   lpma_dma_model i_dma (.mclk_i, .rst_b_i, .go_i(dma_go), .len_i(dma_len),
      .dma_trig_o(dma_trig_i), .dma_busy_o(dma_busy_i));
   // Returns 0 for unclocked or idle, 1 for low and 2 for high frequency.
   function automatic int cls(logic en, logic [2:0] s, logic [31:0] hz, logic u);
      if (!en || s == 3'h0 || s == 3'h6) return 0;
      if (s == 3'h5) return (hz > LIM) ? 2 : (u ? 0 : 1);
      return (s == 3'h2 || s == 3'h3) ? 1 : 2;
   endfunction
   function automatic logic [31:0] pick_hz();
      int k;
      k = $urandom % 3;
      return (k == 0) ? LIM : (k == 1) ? LIM + 32'h1 : 32'($urandom % 32'h00030D40);
   endfunction
   task automatic wt(int n);
      repeat (n) @(negedge mclk_i);
   endtask
   task automatic report_and_stop();
      if (err_count == 0 && n_compared > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic check_mode();
      int k[7];
      int c, l, r;
      k = '{cls(per_en_i[0], per_src_i[0], per_ext_hz_i[0], per_ext_unclk_i[0]),
         cls(per_en_i[1], per_src_i[1], per_ext_hz_i[1], per_ext_unclk_i[1]),
         cls(uart_en_i, uart_wait_start_i ? 3'h6 : uart_src_i, LIM, 1'b0),
         cls(i2ct_en_i, i2ct_wait_start_i ? 3'h6 : 3'h5, i2ct_ext_hz_i, 1'b1),
         cls(spit_en_i, 3'h5, spit_ext_hz_i, spit_slow_unclk_i), cls(seg_en_i, 3'h2, LIM, 1'b0),
         cls(adc_en_i, adc_wait_trig_i ? 3'h6 : adc_src_i, LIM, 1'b0)};
      c = 0;
      foreach (k[i]) if (k[i] > c) c = k[i];
      l = (c == 2) ? 2 : (c == 1) ? 4 : 5;
      r = (cpu_mode_req_i > 3'h5) ? 5 : int'(cpu_mode_req_i);
      `CHK("mode", 3'((r < l) ? r : l), mode_o)
      `CHK("fallback", r > l, fallback_o)
   endtask
   initial begin
      int t;
      void'($urandom(48163));
      wt(20);
      `CHK("reset state", 6'h07, {mode_o, subsys_clk_en_o, aux_clk_en_o, cpu_clk_en_o})
      rst_b_i = 1'b1;
      for (int n = 0; n < 400; n++) begin
         cpu_mode_req_i = 3'($urandom);
         {per_en_i, per_ext_unclk_i} = 4'($urandom);
         for (int i = 0; i < 2; i++) begin
            per_src_i[i] = 3'($urandom % 7);
            per_ext_hz_i[i] = pick_hz();
         end
         {uart_en_i, uart_wait_start_i, i2ct_en_i, i2ct_wait_start_i, spit_en_i, spit_slow_unclk_i,
            seg_en_i, adc_en_i, adc_wait_trig_i, analog_en_i} = 10'($urandom & $urandom);
         uart_src_i = 3'h1 << ($urandom % 2);
         adc_src_i = 3'h1 << ($urandom % 3);
         i2ct_ext_hz_i = pick_hz();
         spit_ext_hz_i = pick_hz();
         wt(3);
         check_mode();
      end
      {per_en_i, uart_en_i, i2ct_en_i, spit_en_i, seg_en_i, adc_en_i} = 7'h0;
      for (int a = 0; a < 3; a++) begin
         cpu_mode_req_i = 3'h0;
         wt(3);
         {crc_busy_i, mpy_busy_i, aes_busy_i} = 3'h4 >> a;
         cpu_mode_req_i = 3'h5;
         wt(3);
         `CHK("held mode", LPMA_ACTIVE, mode_o)
         {crc_busy_i, mpy_busy_i, aes_busy_i} = 3'h0;
         wt(3);
         `CHK("released mode", LPMA_ALL_OFF, mode_o)
      end
      seg_en_i = 1'b1;
      wt(3);
      `CHK("display limit", 2'h3, {mode_o == LPMA_LF_STBY, aux_clk_en_o})
      for (int d = 0; d < 2; d++) begin
         dma_len = d ? 8'h1E : 8'h0;
         dma_go = 1'b1;
         wt(1);
         dma_go = 1'b0;
         wt(1);
         `CHK("wake", 4'h1, {mode_o, dma_active_o})
         for (t = 0; t < 40 && dma_active_o !== 1'b0; t++) wt(1);
         if (t == 40) begin
            err_count++;
            report_and_stop();
         end
         `CHK("after wake", LPMA_LF_STBY, mode_o)
      end
      report_and_stop();
   end
endmodule
